// ---- rtl/pprr_ctrl.sv ----
// Controller end: APB registers and the repair command sequence
`timescale 1ns/1ns
`default_nettype none
`include "pprr_defines.svh"
module pprr_ctrl
   import pprr_pkg::*;
#(
   parameter logic [31:0] PGM_CYC = `PPRR_PGM_CYC  // Programming wait
) (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   pprr_link_if.ctrl        link
);
   ////////////////////////////////////////////////////////////////////
   pprr_cstate_t st_q;
   logic        soft_q;         // Soft mode requested
   logic        wra_q;          // Auto-precharge variant
   logic        skip_q;         // Drive high pattern, no repair
   logic        safe_q;         // Software confirms DBI and CRC off
   logic [1:0]  tbg_q, tba_q;   // Target bank group and bank
   logic [16:0] trow_q;         // Target row
   logic [16:0] restore_q;      // Key register value to put back
   logic        done_q;         // Sequence finished
   logic        abort_q;        // Abort requested
   logic [31:0] tmr_q;          // Wait before next command
   logic [31:0] ref_q;          // Wait before next refresh
   logic [2:0]  idx_q;          // Key step or data beat
   logic        start, wr_acc, setup;
   pprr_cmd_t   cmd_q;
   logic [1:0]  bg_q, ba_q;
   logic [16:0] addr_q;
   logic [15:0] dq_q;
   logic        oe_q;

   // Register hit test, used only for the pslverr_o decode
   function automatic logic hit(input logic [11:0] a);
      return a == `PPRR_OFS_CTRL || a == `PPRR_OFS_TARGET ||
             a == `PPRR_OFS_RESTORE || a == `PPRR_OFS_STATUS;
   endfunction

   // Guard key address for one step
   function automatic logic [16:0] key_addr(input logic [2:0] i);
      logic [4:0] k;
      k = (i == 3'h0) ? `PPRR_KEY0 : (i == 3'h1) ? `PPRR_KEY1 :
          (i == 3'h2) ? `PPRR_KEY2 : `PPRR_KEY3;
      return {5'h00, k, `PPRR_KEY_LOW};
   endfunction

   ////////////////////////////////////////////////////////////////////
   // APB: zero wait states; read data latched in the setup cycle
   assign setup     = psel_i && !penable_i;
   assign wr_acc    = psel_i && penable_i && pwrite_i;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !hit(paddr_i);
   // Start needs the unlock byte and confirmed DBI/CRC off
   assign start = wr_acc && paddr_i == `PPRR_OFS_CTRL && pwdata_i[0]
                  && pwdata_i[15:8] == `PPRR_UNLOCK && pwdata_i[5]
                  && st_q == CS_IDLE;

   // Read mux
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         prdata_o <= 32'h0;
      end else if (setup) begin
         if (paddr_i == `PPRR_OFS_CTRL) begin
            prdata_o <= {26'h0, safe_q, 1'b0, skip_q, wra_q, soft_q, 1'b0};
         end else if (paddr_i == `PPRR_OFS_TARGET) begin
            prdata_o <= {11'h0, trow_q, tba_q, tbg_q};
         end else if (paddr_i == `PPRR_OFS_RESTORE) begin
            prdata_o <= {15'h0, restore_q};
         end else if (paddr_i == `PPRR_OFS_STATUS) begin
            prdata_o <= {26'h0, st_q, done_q, st_q != CS_IDLE};
         end else begin
            prdata_o <= 32'h0;                 // Unmapped reads zero
         end
      end
   end

   // Settings; frozen while a sequence runs
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         soft_q    <= 1'b0;
         wra_q     <= 1'b0;
         skip_q    <= 1'b0;
         safe_q    <= 1'b0;
         tbg_q     <= 2'h0;
         tba_q     <= 2'h0;
         trow_q    <= 17'h0;
         restore_q <= 17'h0;
      end else if (wr_acc && st_q == CS_IDLE) begin
         if (paddr_i == `PPRR_OFS_CTRL) begin
            soft_q <= pwdata_i[1];
            wra_q  <= pwdata_i[2];
            skip_q <= pwdata_i[3];
            safe_q <= pwdata_i[5];
         end else if (paddr_i == `PPRR_OFS_TARGET) begin
            tbg_q  <= pwdata_i[1:0];
            tba_q  <= pwdata_i[3:2];
            trow_q <= pwdata_i[20:4];
         end else if (paddr_i == `PPRR_OFS_RESTORE) begin
            restore_q <= pwdata_i[16:0];
         end
      end
   end

   // Abort request; the set wins over the clear by the sequencer
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         abort_q <= 1'b0;
      end else if (wr_acc && paddr_i == `PPRR_OFS_CTRL && pwdata_i[4] && st_q != CS_IDLE) begin
         abort_q <= 1'b1;
      end else if (st_q == CS_ABORT || st_q == CS_IDLE) begin
         abort_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer; every command is followed by its own wait in tmr_q,
   // during which deselects go out, and refreshes in CS_PGM when wra_q is set
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         st_q   <= CS_IDLE;
         tmr_q  <= 32'h0;
         ref_q  <= 32'h0;
         idx_q  <= 3'h0;
         done_q <= 1'b0;
         cmd_q  <= CMD_DES;
         bg_q   <= 2'h0;
         ba_q   <= 2'h0;
         addr_q <= 17'h0;
         dq_q   <= 16'h0;
         oe_q   <= 1'b0;
      end else begin
         cmd_q <= CMD_DES;
         oe_q  <= 1'b0;
         if (ref_q != 32'h0) begin
            ref_q <= ref_q - 32'h1;
         end
         if (abort_q && st_q != CS_ABORT && st_q != CS_DATA && tmr_q == 32'h0) begin
            st_q <= CS_ABORT;                  // Premature end
         end else if (tmr_q != 32'h0) begin
            tmr_q <= tmr_q - 32'h1;
            if (st_q == CS_PGM && wra_q && ref_q == 32'h0) begin
               cmd_q <= CMD_REF;               // Only refresh while programming
               ref_q <= `PPRR_REFI_CYC - 32'h1;
            end
         end else begin
            case (st_q)
               CS_IDLE: begin
                  if (start) begin
                     st_q   <= CS_PREA;
                     done_q <= 1'b0;
                  end
               end
               CS_PREA: begin
                  cmd_q  <= CMD_PRE;           // All banks closed first
                  addr_q <= 17'h00400;
                  tmr_q  <= `PPRR_RP_CYC - 32'h1;
                  st_q   <= CS_ENTER;
               end
               CS_ENTER: begin
                  cmd_q  <= CMD_MRS;           // Mode entry
                  {bg_q[0], ba_q} <= `PPRR_MR_ENABLE;
                  bg_q[1] <= 1'b0;
                  addr_q <= soft_q ? (17'h1 << `PPRR_BIT_SOFT) : (17'h1 << `PPRR_BIT_HARD);
                  tmr_q  <= `PPRR_T_MOD_CK - 32'h1;
                  idx_q  <= 3'h0;
                  st_q   <= CS_KEY;
               end
               CS_KEY: begin
                  cmd_q  <= CMD_MRS;           // Back to back keys, nothing between
                  bg_q   <= 2'h0;
                  ba_q   <= 2'h0;
                  addr_q <= key_addr(idx_q);
                  tmr_q  <= `PPRR_T_MOD_CK - 32'h1;
                  idx_q  <= idx_q + 3'h1;
                  if (idx_q == 3'h3) begin
                     st_q <= CS_ACT;
                  end
               end
               CS_ACT: begin
                  cmd_q  <= CMD_ACT;           // Failing row
                  bg_q   <= tbg_q;
                  ba_q   <= tba_q;
                  addr_q <= trow_q;
                  tmr_q  <= `PPRR_RCD_CYC - 32'h1;
                  st_q   <= CS_WRITE;
               end
               CS_WRITE: begin
                  cmd_q  <= wra_q ? CMD_WRA : CMD_WR;
                  addr_q <= 17'h0;
                  tmr_q  <= `PPRR_WL_CK - 32'h1;  // First beat seen WL after write
                  idx_q  <= 3'h0;
                  st_q   <= CS_DATA;
               end
               CS_DATA: begin
                  oe_q  <= 1'b1;               // Low asks repair, high skips
                  dq_q  <= skip_q ? 16'hffff : 16'h0000;
                  idx_q <= idx_q + 3'h1;
                  if (idx_q == `PPRR_BEATS - 3'h1) begin
                     tmr_q <= PGM_CYC;         // Programming time
                     ref_q <= `PPRR_WR_CYC + `PPRR_RP_CYC;  // First refresh
                     st_q  <= CS_PGM;
                  end
               end
               CS_PGM: begin
                  cmd_q <= CMD_PRE;            // No refresh in plain variant
                  addr_q <= 17'h0;
                  bg_q  <= tbg_q;
                  ba_q  <= tba_q;
                  tmr_q <= `PPRR_EXIT_CYC - 32'h1;
                  st_q  <= CS_EXIT;
               end
               CS_EXIT, CS_ABORT: begin
                  cmd_q  <= CMD_MRS;           // Clear the mode bit
                  {bg_q[0], ba_q} <= `PPRR_MR_ENABLE;
                  bg_q[1] <= 1'b0;
                  addr_q <= 17'h0;
                  tmr_q  <= `PPRR_PST_CYC - 32'h1;   // Settle, nothing sent
                  st_q   <= CS_POST;
               end
               CS_POST: begin
                  cmd_q  <= CMD_MRS;           // Put the key register back
                  bg_q   <= 2'h0;
                  ba_q   <= 2'h0;
                  addr_q <= restore_q;
                  tmr_q  <= `PPRR_T_MOD_CK - 32'h1;
                  st_q   <= CS_MR0;
               end
               default: begin
                  done_q <= 1'b1;
                  st_q   <= CS_IDLE;
               end
            endcase
         end
      end
   end

   assign link.cmd   = cmd_q;
   assign link.bg    = bg_q;
   assign link.ba    = ba_q;
   assign link.addr  = addr_q;
   assign link.dq    = dq_q;
   assign link.dq_oe = oe_q;
endmodule // pprr_ctrl
`default_nettype wire

// ---- rtl/pprr_defines.svh ----
// Constants for the row repair sequencer and its controller
`ifndef PPRR_DEFINES_SVH
`define PPRR_DEFINES_SVH
`define PPRR_CLK_MHZ      50
`define PPRR_BIT_HARD     13
`define PPRR_BIT_SOFT     5
`define PPRR_MR_ENABLE    3'h4
`define PPRR_MR_KEY       3'h0
`define PPRR_KEY0         5'h19
`define PPRR_KEY1         5'h0f
`define PPRR_KEY2         5'h17
`define PPRR_KEY3         5'h07
`define PPRR_KEY_LOW      7'h7f
`define PPRR_BEATS        3'h4
`define PPRR_SKIP_BEATS   3'h2
`define PPRR_WL_CK        32'd11
`define PPRR_T_MOD_CK     32'd24
`define PPRR_T_RCD_NS     15
`define PPRR_T_RP_NS      15
`define PPRR_T_WR_NS      15
`define PPRR_T_EXIT_NS    15
`define PPRR_T_PST_US     50
`define PPRR_T_REFI_NS    7800
`define PPRR_T_PGM_MS     2000
`define PPRR_NS_CEIL(t)   (((t) * `PPRR_CLK_MHZ + 999) / 1000)
`define PPRR_RCD_CYC      `PPRR_NS_CEIL(`PPRR_T_RCD_NS)
`define PPRR_RP_CYC       `PPRR_NS_CEIL(`PPRR_T_RP_NS)
`define PPRR_WR_CYC       `PPRR_NS_CEIL(`PPRR_T_WR_NS)
`define PPRR_EXIT_CYC     `PPRR_NS_CEIL(`PPRR_T_EXIT_NS)
`define PPRR_PST_CYC      (`PPRR_T_PST_US * `PPRR_CLK_MHZ)
`define PPRR_REFI_CYC     ((`PPRR_T_REFI_NS * `PPRR_CLK_MHZ) / 1000)
`define PPRR_PGM_CYC      (`PPRR_T_PGM_MS * 1000 * `PPRR_CLK_MHZ)
`define PPRR_OFS_CTRL     12'h000
`define PPRR_OFS_TARGET   12'h004
`define PPRR_OFS_RESTORE  12'h008
`define PPRR_OFS_STATUS   12'h00c
`define PPRR_UNLOCK       8'ha5
`endif

// ---- rtl/pprr_dev.sv ----
// Memory end: mode entry, guard key, repair capture and fuses
`timescale 1ns/1ns
`default_nettype none
`include "pprr_defines.svh"
module pprr_dev
   import pprr_pkg::*;
#(
   parameter bit KEY_LOW_STRICT = 1'b1  // Demand all-ones low key bits
) (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   input  wire logic        por_i,        // Blank-die power-on, clears fuses
   pprr_link_if.mem         link,
   output logic [1:0]       hard_used_o,  // Hard fuse used per group
   output logic [1:0]       soft_used_o,  // Soft repair held per group
   output logic [16:0]      rep_row_o [2],// Replaced row per group
   output logic             ref_o,        // Refresh performed, pulse
   output logic             ref_excl_o,   // Refresh skips one bank pair
   output logic             ref_excl_bg_o,// Group of skipped pair
   output logic             ref_excl_ba1_o// Bank bit 1 of skipped pair
);
   ////////////////////////////////////////////////////////////////////
   pprr_dstate_t st_q;
   logic        hard_q, soft_q;   // Current mode bits
   logic        wra_q;            // Auto-precharge variant
   logic        tbg_q;            // Target group (x16: one bit)
   logic [1:0]  tba_q;            // Target bank
   logic [16:0] trow_q;           // Target row
   logic [31:0] wl_q;             // Wait for first data beat
   logic [2:0]  beat_q;           // Data beat index
   logic        low_q, high_q;    // Pattern trackers
   logic [1:0]  fuse_q;           // Survives reset_i
   logic [16:0] frow_q [2];       // Fused row per group
   logic [1:0]  soft_q2;          // Soft repair present
   logic [16:0] srow_q [2];       // Soft row per group
   logic        mrs4, mrs0, busy_cmd;
   logic        dq_low, dq_high;

   // Key check for one step; BG1 ignored on this width
   function automatic logic key_ok(input logic [1:0] step);
      logic [4:0] k;
      k = (step == 2'h0) ? `PPRR_KEY0 : (step == 2'h1) ? `PPRR_KEY1 :
          (step == 2'h2) ? `PPRR_KEY2 : `PPRR_KEY3;
      return mrs0 && (link.bg[0] == 1'b0) && (link.ba == 2'h0) &&
             (link.addr[11:7] == k) &&
             (!KEY_LOW_STRICT || link.addr[6:0] == `PPRR_KEY_LOW);
   endfunction

   assign mrs4 = (link.cmd == CMD_MRS) && ({link.bg[0], link.ba} == `PPRR_MR_ENABLE);
   assign mrs0 = (link.cmd == CMD_MRS) && ({link.bg[0], link.ba} == `PPRR_MR_KEY);
   assign busy_cmd = (link.cmd != CMD_DES);
   assign dq_low  = link.dq_oe && (link.dq == 16'h0000);
   assign dq_high = link.dq_oe && (link.dq == 16'hffff);

   ////////////////////////////////////////////////////////////////////
   // Mode bits follow every enable-register write
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         hard_q <= 1'b0;
         soft_q <= 1'b0;
      end else if (mrs4) begin
         hard_q <= link.addr[`PPRR_BIT_HARD];
         soft_q <= link.addr[`PPRR_BIT_SOFT];
      end
   end

   // Sequencer; a failed key just parks until the mode bit clears,
   // with no flag anywhere, so later commands act as plain accesses
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         st_q <= DS_IDLE;
      end else if (mrs4 && !link.addr[`PPRR_BIT_HARD] && !link.addr[`PPRR_BIT_SOFT]) begin
         st_q <= DS_IDLE;                      // Exit clears any stage
      end else begin
         case (st_q)
            DS_IDLE: begin
               if (mrs4) begin
                  st_q <= DS_K0;               // Entry, key must follow
               end
            end
            DS_K0, DS_K1, DS_K2, DS_K3: begin
               if (busy_cmd) begin
                  if (!key_ok({st_q == DS_K2 || st_q == DS_K3,
                               st_q == DS_K1 || st_q == DS_K3})) begin
                     st_q <= DS_FAIL;          // Out of order or interrupted
                  end else if (st_q == DS_K0) begin
                     st_q <= DS_K1;
                  end else if (st_q == DS_K1) begin
                     st_q <= DS_K2;
                  end else if (st_q == DS_K2) begin
                     st_q <= DS_K3;
                  end else begin
                     st_q <= DS_ARMED;         // Armed only after four in order
                  end
               end
            end
            DS_ARMED: begin
               if (link.cmd == CMD_ACT) begin
                  st_q <= DS_ROW;
               end
            end
            DS_ROW: begin
               if (link.cmd == CMD_WR || link.cmd == CMD_WRA) begin
                  st_q <= DS_DATA;
               end
            end
            DS_DATA: begin
               if (wl_q == 32'h0 && beat_q == `PPRR_BEATS - 3'h1) begin
                  st_q <= DS_PGM;
               end
            end
            default: begin
               st_q <= st_q;                   // PGM and FAIL wait for exit
            end
         endcase
      end
   end

   // Target capture; write column address is ignored
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         tbg_q  <= 1'b0;
         tba_q  <= 2'h0;
         trow_q <= 17'h0;
         wra_q  <= 1'b0;
      end else if (st_q == DS_ARMED && link.cmd == CMD_ACT) begin
         tbg_q  <= link.bg[0];
         tba_q  <= link.ba;
         trow_q <= link.addr;
      end else if (st_q == DS_ROW && busy_cmd) begin
         wra_q  <= (link.cmd == CMD_WRA);
      end
   end

   // Data window: WL, then four beats checked
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         wl_q   <= 32'h0;
         beat_q <= 3'h0;
         low_q  <= 1'b0;
         high_q <= 1'b0;
      end else if (st_q == DS_ROW) begin
         wl_q   <= `PPRR_WL_CK - 32'h1;
         beat_q <= 3'h0;
         low_q  <= 1'b1;
         high_q <= 1'b1;
      end else if (st_q == DS_DATA) begin
         if (wl_q != 32'h0) begin
            wl_q <= wl_q - 32'h1;
         end else begin
            beat_q <= beat_q + 3'h1;
            low_q  <= low_q & dq_low;          // All four low asks repair
            if (beat_q < `PPRR_SKIP_BEATS) begin
               high_q <= high_q & dq_high;     // First two high skips
            end
         end
      end
   end

   // Fuses: set once per group, reset_i never clears them
   always_ff @(posedge clk_sys_i) begin
      if (por_i) begin
         fuse_q <= 2'h0;
         frow_q <= '{17'h0, 17'h0};
      end else if (st_q == DS_DATA && wl_q == 32'h0 && beat_q == `PPRR_BEATS - 3'h1
                   && hard_q && low_q && dq_low && !high_q && !fuse_q[tbg_q]) begin
         fuse_q[tbg_q] <= 1'b1;
         frow_q[tbg_q] <= trow_q;
      end
   end

   // Soft repair is volatile and lost on reset; needs an unused group
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         soft_q2 <= 2'h0;
         srow_q  <= '{17'h0, 17'h0};
      end else if (st_q == DS_DATA && wl_q == 32'h0 && beat_q == `PPRR_BEATS - 3'h1
                   && soft_q && !hard_q && low_q && dq_low && !high_q
                   && !fuse_q[tbg_q] && !soft_q2[tbg_q]) begin
         soft_q2[tbg_q] <= 1'b1;
         srow_q[tbg_q]  <= trow_q;
      end
   end

   // Refresh report; in the auto-precharge variant the repaired pair
   // is left out, bank bit 0 not considered
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ref_o          <= 1'b0;
         ref_excl_o     <= 1'b0;
         ref_excl_bg_o  <= 1'b0;
         ref_excl_ba1_o <= 1'b0;
      end else begin
         ref_o          <= (link.cmd == CMD_REF);
         ref_excl_o     <= (link.cmd == CMD_REF) && st_q == DS_PGM && wra_q;
         ref_excl_bg_o  <= tbg_q;
         ref_excl_ba1_o <= tba_q[1];
      end
   end

   // Fuse wins over soft repair in a group
   always_comb begin
      for (int g = 0; g < 2; g++) begin
         rep_row_o[g] = fuse_q[g] ? frow_q[g] : srow_q[g];
      end
   end
   assign hard_used_o = fuse_q;
   assign soft_used_o = soft_q2 & ~fuse_q;
endmodule // pprr_dev
`default_nettype wire

// ---- rtl/pprr_link_if.sv ----
// Command, address and data link between controller and memory
`timescale 1ns/1ns
`default_nettype none
interface pprr_link_if;
   import pprr_pkg::*;
   pprr_cmd_t   cmd;    // Command of this cycle
   logic [1:0]  bg;     // Bank group
   logic [1:0]  ba;     // Bank; also mode register number low bits
   logic [16:0] addr;   // Row or mode register value
   logic [15:0] dq;     // Write data
   logic        dq_oe;  // Controller drives data
   modport ctrl (output cmd, bg, ba, addr, dq, dq_oe);
   modport mem  (input cmd, bg, ba, addr, dq, dq_oe);
endinterface
`default_nettype wire

// ---- rtl/pprr_pkg.sv ----
// Types shared by both ends of the repair link
package pprr_pkg;
   // Link commands, one per memory clock
   typedef enum logic [2:0] {
      CMD_DES = 3'h0, CMD_MRS = 3'h1, CMD_ACT = 3'h2, CMD_WR = 3'h3,
      CMD_WRA = 3'h4, CMD_PRE = 3'h5, CMD_REF = 3'h6, CMD_OTH = 3'h7
   } pprr_cmd_t;
   // Device sequencer states, Gray along the repair path
   typedef enum logic [3:0] {
      DS_IDLE = 4'h0, DS_K0 = 4'h1, DS_K1 = 4'h3, DS_K2 = 4'h2, DS_K3 = 4'h6,
      DS_ARMED = 4'h7, DS_ROW = 4'h5, DS_DATA = 4'h4, DS_PGM = 4'hc,
      DS_FAIL = 4'h8
   } pprr_dstate_t;
   // Controller states, Gray along the repair path except the step from CS_PGM to CS_EXIT
   typedef enum logic [3:0] {
      CS_IDLE = 4'h0, CS_PREA = 4'h1, CS_ENTER = 4'h3, CS_KEY = 4'h2,
      CS_ACT = 4'h6, CS_WRITE = 4'h7, CS_DATA = 4'h5, CS_PGM = 4'h4,
      CS_PRE = 4'hc, CS_EXIT = 4'hd, CS_POST = 4'hf, CS_MR0 = 4'he,
      CS_ABORT = 4'h8
   } pprr_cstate_t;
endpackage

// ---- tb/pprr_asserts.sv ----
// Link protocol checks on the controller-to-memory repair link
`timescale 1ns/1ns
`default_nettype none
module pprr_asserts
   import pprr_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        reset_i,
   input wire pprr_cmd_t   cmd,
   input wire logic [1:0]  bg,
   input wire logic [1:0]  ba,
   input wire logic [16:0] addr,
   input wire logic [15:0] dq,
   input wire logic        dq_oe
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   logic [7:0]       gap_q;  // Cycles since last mode write, saturating
   logic             wr_q;   // Plain-write repair in progress
   // Key code of a well-formed key write, else an unused code
   wire logic [4:0]  kc = (cmd == CMD_MRS && bg == 2'h0 && ba == 2'h0 && addr[6:0] == 7'h7f)
                          ? addr[11:7] : 5'h1f;
   wire logic        ent = cmd == CMD_MRS && {bg[0], ba} == 3'h4 && (addr[13] || addr[5]);
   // Starts saturated so the first mode write after reset is legal
   always_ff @(posedge clk_sys_i) begin
      gap_q <= (reset_i) ? 8'hff : (cmd == CMD_MRS) ? 8'h00 : gap_q + {7'h0, gap_q != 8'hff};
   end
   // Refresh is illegal until the mode exit write
   always_ff @(posedge clk_sys_i) begin
      wr_q <= !reset_i && (cmd == CMD_WR || (wr_q && cmd != CMD_MRS));
   end
   a_key_order: assert property (ent |-> ##24 kc == 5'h19 ##24 kc == 5'h0f ##24 kc == 5'h17
      ##24 kc == 5'h07) else $error("guard key out of order");
   a_mode_one: assert property (ent |-> !(addr[13] && addr[5])) else $error("both modes");
   a_key_gap: assert property (cmd == CMD_MRS |-> gap_q >= 8'd23) else $error("mode gap");
   a_act_write: assert property (cmd == CMD_ACT |=> cmd inside {CMD_WR, CMD_WRA})
      else $error("no write after activate");
   a_dq_burst: assert property (cmd inside {CMD_WR, CMD_WRA} |-> ##11 dq_oe [*4] ##1 !dq_oe)
      else $error("data burst timing");
   a_dq_level: assert property (dq_oe |-> dq == 16'h0000 || dq == 16'hffff)
      else $error("data pattern");
   a_wr_noref: assert property (wr_q |-> cmd != CMD_REF) else $error("refresh in write case");
   a_pgm_quiet: assert property (cmd inside {CMD_WR, CMD_WRA} |-> ##16 (cmd inside {CMD_DES,
      CMD_REF}) [*8]) else $error("command during programming");
endmodule // pprr_asserts
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench: both repair ends joined, driven over APB
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import pprr_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        por_i = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, perr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [1:0]  hard_used, soft_used, hexp = 2'h0, sexp = 2'h0;
   logic [16:0] rep_row [2], rexp [2], row;
   int          err_count = 0, n_compared = 0, cyc = 0, g, grp;
   int          n_ref = 0;                          // Refresh pulses seen
   logic [31:0] rsv;                                // Key register restore value
   logic [16:0] mr0_seen;                           // Last key register write on link
   logic [1:0]  bexp;                               // Target bank of this repair
   logic        ref_p, ref_x, ref_xbg, ref_xba1;    // Refresh report of the memory end
   always #10 clk_sys_i = ~clk_sys_i;
   pprr_link_if link_if ();
   pprr_ctrl #(.PGM_CYC(32'd200)) u_pprr_ctrl (.clk_sys_i, .reset_i, .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(link_if.ctrl));
   pprr_dev u_pprr_dev (.clk_sys_i, .reset_i, .por_i, .link(link_if.mem),
      .hard_used_o(hard_used), .soft_used_o(soft_used), .rep_row_o(rep_row), .ref_o(ref_p),
      .ref_excl_o(ref_x), .ref_excl_bg_o(ref_xbg), .ref_excl_ba1_o(ref_xba1));
   pprr_asserts u_chk (.clk_sys_i, .reset_i, .cmd(link_if.cmd), .bg(link_if.bg),
      .ba(link_if.ba), .addr(link_if.addr), .dq(link_if.dq), .dq_oe(link_if.dq_oe));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h, expected %h", $time, s, e);
      end
   endtask
   // One APB transfer; holds the request until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do @(posedge clk_sys_i); while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // A hung sequence would otherwise poll forever
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end
   // Refresh must spare the repaired pair; remember the last key register write
   always @(posedge clk_sys_i) begin
      if (ref_p) begin
         n_ref++;
         chk({29'h0, ref_x, ref_xbg, ref_xba1}, {29'h0, 1'b1, 1'(grp), bexp[1]});
      end
      if (link_if.cmd == CMD_MRS && {link_if.bg[0], link_if.ba} == 3'h0) begin
         mr0_seen <= link_if.addr;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Hard plain write, hard auto-precharge skipped, then soft on the second group
   initial begin
      void'($urandom(32'hed41));
      g = $urandom % 2;
      repeat (6) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      por_i <= 1'b0;
      @(posedge clk_sys_i);
      apb(1'b0, 12'h010, 32'h0);
      chk({perr, rd[30:0]}, 32'h80000000);
      $display("unmapped access done");
      rsv = $urandom & 32'h0001f07f;
      apb(1'b1, 12'h008, rsv);
      apb(1'b1, 12'h000, 32'h00000021);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 12'h000, 32'h0000a501);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, 32'h0);
      $display("start guard test done");
      for (int t = 0; t < 3; t++) begin
         grp = (t == 0) ? g : 1 - g;
         row = 17'($urandom);
         bexp = 2'($urandom);
         apb(1'b1, 12'h004, {11'h0, row, bexp, 1'b0, 1'(grp)});
         apb(1'b1, 12'h000, 32'h0000a521 | {28'h0, t == 1, t == 1, t == 2, 1'b0});
         do apb(1'b0, 12'h00c, 32'h0); while (rd[0] !== 1'b0);
         chk({31'h0, rd[1]}, 32'h1);
         chk({15'h0, mr0_seen}, rsv);
         if (t != 1) begin
            if (t == 2) sexp[grp] = 1'b1;
            else hexp[grp] = 1'b1;
            rexp[grp] = row;
            chk({15'h0, rep_row[grp]}, {15'h0, rexp[grp]});
         end
         chk({30'h0, hard_used}, {30'h0, hexp});
         chk({30'h0, soft_used}, {30'h0, sexp & ~hexp});
         $display("repair test %0d done", t);
      end
      chk(n_ref, 32'h1);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      chk({30'h0, hard_used}, {30'h0, hexp});
      chk({15'h0, rep_row[g]}, {15'h0, rexp[g]});
      chk({30'h0, soft_used}, 32'h0);
      $display("reset test done");
      close_out();
   end
endmodule // tb_top
`default_nettype wire
